// ---- crcp_chain_model.sv ----
// Neighbouring codecs on the frame sync and daisy pins during discovery.
// Assumes the device leaves reset in step with its neighbours.
`timescale 1ns/1ps
module crcp_chain_model (
  // Clock and the device's internal reset.
  input wire logic clock,
  input wire logic core_reset_n,
  // Device side of both probe pins.
  input wire logic fs_drive,
  input wire logic fs_oe,
  input wire logic daisy_drive,
  input wire logic daisy_oe,
  // Devices below and above this one in the chain.
  input wire logic [4:0] below,
  input wire logic [4:0] above,
  // Resolved pin levels.
  output logic fs_wire,
  output logic daisy_wire
);
  logic [7:0] cnt = 8'h00;
  logic tog = 1'b0;
  logic [7:0] rise_at;
  logic [7:0] fall_at;

  // Clocks since discovery began; a released line toggles so that no
  // stale level can pass for a real answer.
  always_ff @(posedge clock) begin
    tog <= !tog;
    cnt <= !core_reset_n ? 8'h00 : (cnt == 8'hFF ? cnt : cnt + 8'h01);
  end

  // Each neighbour adds one three-clock hop to the probe edge.
  assign rise_at = 8'(3 * below);
  assign fall_at = 8'h40 + 8'(3 * above);

  // Pin resolution: the device's enable wins, then the neighbours.
  always_comb begin
    if (daisy_oe) begin
      daisy_wire = daisy_drive;
    end else if (below == 5'h00) begin
      daisy_wire = 1'b1;
    end else if (cnt < 8'h40 || !core_reset_n) begin
      // Neighbours in reset show the level of discovery's first clock.
      daisy_wire = core_reset_n && (cnt >= rise_at);
    end else begin
      daisy_wire = tog;
    end
    if (fs_oe) begin
      fs_wire = fs_drive;
    end else if (above != 5'h00 && cnt >= 8'h40 && cnt < 8'h84) begin
      fs_wire = (cnt < fall_at);
    end else begin
      fs_wire = tog;
    end
  end
endmodule

// ---- crcp_core.sv ----
// Reset sequencing, cascade discovery and power-down control of one codec.
// Assumes the serial port logic reports frame starts and frame type on
// the master clock, and that neighbours run the same discovery in step.
`timescale 1ns/1ps
module crcp_core (
  // Clock and power-on reset.
  input wire logic clock,
  input wire logic resetn,
  // External pins: hardware reset, power-down and master/slave strap.
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  input wire logic master_select,
  // Frame sync pin.
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  // Frame sync daisy pin.
  input wire logic frame_sync_daisy_in,
  output logic frame_sync_daisy_out,
  output logic frame_sync_daisy_oe,
  // Frame sync drive requested by the serial port after discovery.
  input wire logic port_fs_out,
  input wire logic port_fs_oe,
  // Frame timing from the serial port.
  input wire logic frame_start,
  input wire logic data_frame,
  // Control register 3 write from a control frame.
  input wire logic reg3_write,
  input wire logic [7:0] reg3_wdata,
  output logic [7:0] reg3_value,
  // Discovery results.
  output crcp_pkg::crcp_chain_s chain,
  // Serial port gating.
  output logic dout_enable,
  output logic din_ctrl_accept,
  output logic din_data_accept,
  // Power enables for the converters and the rest of the device.
  output crcp_pkg::crcp_power_s power,
  // Internal reset handed to the rest of the codec, active low.
  output logic core_reset_n
);

  // Synchronised copies of every pin.
  logic reset_pin_sync;
  logic power_pin_sync;
  logic master_sync;
  logic fs_sync;
  logic daisy_sync;

  // Sequencer state.
  crcp_pkg::crcp_state_e state;
  crcp_pkg::crcp_state_e next_state;
  logic [7:0] cycle;
  logic [7:0] next_cycle;
  crcp_pkg::crcp_chain_s next_chain;

  // Probe drive registers.
  crcp_pkg::crcp_pin_s fs_probe;
  crcp_pkg::crcp_pin_s daisy_probe;
  crcp_pkg::crcp_pin_s next_fs_probe;
  crcp_pkg::crcp_pin_s next_daisy_probe;

  // Control register 3 and applied power-down state.
  logic [7:0] next_reg3_value;
  logic sw_reset_req;
  logic next_sw_reset_req;
  logic pd_adc;
  logic pd_dac;
  logic next_pd_adc;
  logic next_pd_dac;

  // Phase counter results.
  logic [crcp_pkg::COUNT_W-1:0] down_hops;
  logic [crcp_pkg::COUNT_W-1:0] up_hops;
  logic down_found;
  logic up_found;

  // Combined reset and decoded conditions.
  logic reset_now;
  logic hw_pd;
  logic sw_pd;
  logic probing_down;
  logic probing_up;
  logic last_in_chain;
  logic [crcp_pkg::COUNT_W-1:0] total;

  // Every pin from outside passes two flops before any logic.
  crcp_sync #(
    .RESET_VALUE(1'b0)
  ) u_sync_reset (
    .clock(clock),
    .resetn(resetn),
    .pin(reset_pin_n),
    .level(reset_pin_sync)
  );

  crcp_sync #(
    .RESET_VALUE(1'b1)
  ) u_sync_power (
    .clock(clock),
    .resetn(resetn),
    .pin(power_down_pin_n),
    .level(power_pin_sync)
  );

  crcp_sync #(
    .RESET_VALUE(1'b0)
  ) u_sync_master (
    .clock(clock),
    .resetn(resetn),
    .pin(master_select),
    .level(master_sync)
  );

  crcp_sync #(
    .RESET_VALUE(1'b0)
  ) u_sync_fs (
    .clock(clock),
    .resetn(resetn),
    .pin(frame_sync_in),
    .level(fs_sync)
  );

  crcp_sync #(
    .RESET_VALUE(1'b0)
  ) u_sync_daisy (
    .clock(clock),
    .resetn(resetn),
    .pin(frame_sync_daisy_in),
    .level(daisy_sync)
  );

  // Either reset source, or the power-on reset, clears the block; the sync flops and the reset request clear on the power-on reset alone.
  // The pin reset stays in force for as long as the pin is low.
  assign reset_now = !resetn || !reset_pin_sync || sw_reset_req;
  assign core_reset_n = !reset_now;

  assign hw_pd = !power_pin_sync;
  assign sw_pd = pd_adc && pd_dac;
  assign probing_down = (state == crcp_pkg::CRCP_PROBE_DOWN);
  assign probing_up = (state == crcp_pkg::CRCP_PROBE_UP);
  // A device that saw the daisy level at once sits at the end.
  assign last_in_chain = (down_hops == '0);
  // Zero-based hop counts, so the sum plus one is the chain length.
  assign total = down_hops + up_hops + 1'b1;

  // Phase one: distance to the end of the chain, seen as daisy going high.
  crcp_phase_counter #(
    .COUNT_W(crcp_pkg::COUNT_W),
    .HOP_CYCLES(crcp_pkg::HOP_CYCLES)
  ) u_count_down (
    .clock(clock),
    .resetn(resetn),
    .clear(state == crcp_pkg::CRCP_HOLD),
    .active(probing_down),
    .seen(daisy_sync),
    .hops(down_hops),
    .found(down_found)
  );

  // Phase two: distance from the master, seen as frame sync pulled low.
  crcp_phase_counter #(
    .COUNT_W(crcp_pkg::COUNT_W),
    .HOP_CYCLES(crcp_pkg::HOP_CYCLES)
  ) u_count_up (
    .clock(clock),
    .resetn(resetn),
    .clear(state == crcp_pkg::CRCP_HOLD),
    .active(probing_up && !master_sync),
    .seen(!fs_sync),
    .hops(up_hops),
    .found(up_found)
  );

  // Sequencer: a fixed 132-clock run from the end of any reset, the same
  // length whatever the chain, so all devices finish together.
  always_comb begin
    next_state = state;
    next_cycle = cycle + 8'h01;
    next_chain = chain;
    case (state)
      crcp_pkg::CRCP_HOLD: begin
        next_cycle = 8'h00;
        next_chain = '0;
        next_state = crcp_pkg::CRCP_PROBE_DOWN;
      end
      crcp_pkg::CRCP_PROBE_DOWN: begin
        if (cycle == crcp_pkg::PHASE_CYCLES - 8'h01) begin
          next_state = crcp_pkg::CRCP_PROBE_UP;
        end
      end
      crcp_pkg::CRCP_PROBE_UP: begin
        if (cycle == crcp_pkg::PHASE_CYCLES + crcp_pkg::PHASE_CYCLES
            - 8'h01) begin
          next_state = crcp_pkg::CRCP_SETTLE;
        end
      end
      crcp_pkg::CRCP_SETTLE: begin
        if (cycle == crcp_pkg::INIT_CYCLES - 8'h01) begin
          next_state = crcp_pkg::CRCP_RUN;
          // Addresses count up from the end; the master is highest.
          next_chain.address = down_hops[crcp_pkg::ADDR_W-1:0];
          next_chain.length = total;
          next_chain.is_master = master_sync;
          next_chain.is_last = last_in_chain;
          next_chain.ready = 1'b1;
        end
      end
      crcp_pkg::CRCP_RUN: begin
        next_cycle = cycle;
      end
      default: begin
        next_state = crcp_pkg::CRCP_HOLD;
        next_cycle = 8'h00;
      end
    endcase
  end

  // Sequencer registers; the internal reset holds it at the start.
  always_ff @(posedge clock) begin
    if (reset_now) begin
      state <= crcp_pkg::CRCP_HOLD;
      cycle <= 8'h00;
      chain <= '0;
    end else begin
      state <= next_state;
      cycle <= next_cycle;
      chain <= next_chain;
    end
  end

  // Probe drives. Phase one passes the daisy level up on frame sync;
  // phase two passes a low from the master down on the daisy pins.
  // The master never releases frame sync, and the end device never
  // drives its daisy pin, which has a pull-up outside.
  always_comb begin
    next_fs_probe = '0;
    next_daisy_probe = '0;
    case (next_state)
      crcp_pkg::CRCP_PROBE_DOWN: begin
        next_fs_probe.enable = 1'b1;
        next_fs_probe.drive = daisy_sync;
      end
      crcp_pkg::CRCP_PROBE_UP: begin
        next_fs_probe.enable = master_sync;
        next_fs_probe.drive = 1'b1;
        next_daisy_probe.enable = !last_in_chain;
        next_daisy_probe.drive = master_sync ? 1'b0 : fs_sync;
      end
      crcp_pkg::CRCP_HOLD, crcp_pkg::CRCP_SETTLE: begin
        next_fs_probe.enable = master_sync;
        next_fs_probe.drive = (next_state == crcp_pkg::CRCP_SETTLE);
      end
      default: begin
        next_fs_probe = '0;
        next_daisy_probe = '0;
      end
    endcase
  end

  // Probe drive registers.
  always_ff @(posedge clock) begin
    if (reset_now) begin
      fs_probe <= '0;
      daisy_probe <= '0;
    end else begin
      fs_probe <= next_fs_probe;
      daisy_probe <= next_daisy_probe;
    end
  end

  // Pin outputs. After discovery the serial port owns frame sync, but
  // the hardware power-down still releases every digital output.
  always_comb begin
    if (chain.ready) begin
      frame_sync_out = port_fs_out;
      frame_sync_oe = port_fs_oe && !hw_pd;
      frame_sync_daisy_out = 1'b0;
      frame_sync_daisy_oe = 1'b0;
    end else begin
      frame_sync_out = fs_probe.drive;
      frame_sync_oe = (fs_probe.enable || master_sync) && !hw_pd;
      frame_sync_daisy_out = daisy_probe.drive;
      frame_sync_daisy_oe = daisy_probe.enable && !hw_pd;
    end
  end

  // Control register 3. A write with the reset bit set is not stored:
  // it raises a one-clock internal reset, which reloads the default.
  // Writes are taken in software power-down, never in hardware.
  always_comb begin
    next_reg3_value = reg3_value;
    next_sw_reset_req = 1'b0;
    if (reg3_write && chain.ready && !hw_pd) begin
      if (reg3_wdata[crcp_pkg::REG3_SW_RESET_BIT]) begin
        next_sw_reset_req = 1'b1;
      end else begin
        next_reg3_value = reg3_wdata;
      end
    end
  end

  // Only a reset or a write touches this register; power-down leaves it alone.
  always_ff @(posedge clock) begin
    if (reset_now) begin
      reg3_value <= crcp_pkg::REG3_RESET;
    end else begin
      reg3_value <= next_reg3_value;
    end
  end

  // The reset request clears only on the power-on reset, so that it
  // lives for exactly the clock after the write.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sw_reset_req <= 1'b0;
    end else begin
      sw_reset_req <= next_sw_reset_req;
    end
  end

  // Power-down bits take effect, and release, at a frame start so a
  // frame is never cut in the middle.
  always_comb begin
    next_pd_adc = pd_adc;
    next_pd_dac = pd_dac;
    if (frame_start) begin
      next_pd_adc = reg3_value[crcp_pkg::REG3_PD_ADC_BIT];
      next_pd_dac = reg3_value[crcp_pkg::REG3_PD_DAC_BIT];
    end
  end

  // Applied power-down state.
  always_ff @(posedge clock) begin
    if (reset_now) begin
      pd_adc <= 1'b0;
      pd_dac <= 1'b0;
    end else begin
      pd_adc <= next_pd_adc;
      pd_dac <= next_pd_dac;
    end
  end

  // Serial gating. Output drops only in data frames of software
  // power-down; control frames keep working so software can wake it.
  assign dout_enable = chain.ready && !hw_pd
                       && !(sw_pd && data_frame);
  assign din_ctrl_accept = chain.ready && !hw_pd && !data_frame;
  assign din_data_accept = chain.ready && !hw_pd && data_frame
                           && !sw_pd;

  // Power enables. The converters follow their own bits; the
  // differential outputs follow the output side.
  always_comb begin
    power.adc_on = chain.ready && !hw_pd && !pd_adc;
    power.dac_on = chain.ready && !hw_pd && !pd_dac;
    power.analog_out_on = chain.ready && !hw_pd && !pd_dac;
    power.clock_ctrl_on = !hw_pd;
    power.digital_io_on = !hw_pd;
  end

endmodule

// ---- crcp_core_monitor.sv ----
// Checker for the reset, cascade discovery and power-down block.
// Assumes it is bound to crcp_core and sees only that module's ports.
`timescale 1ns/1ps
module crcp_core_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Pins, frame timing and register writes.
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  input wire logic master_select,
  input wire logic frame_start,
  input wire logic data_frame,
  input wire logic reg3_write,
  input wire logic [7:0] reg3_wdata,
  // Outputs under watch.
  input wire logic frame_sync_oe,
  input wire logic [7:0] reg3_value,
  input wire crcp_pkg::crcp_chain_s chain,
  input wire logic dout_enable,
  input wire logic din_ctrl_accept,
  input wire logic din_data_accept,
  input wire crcp_pkg::crcp_power_s power,
  input wire logic core_reset_n
);
  // One clock domain, so clock and disable are stated once.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Pin levels pass two sync flops, hence the three-sample antecedents.
  a_hw_pd_gates: assert property (
    !power_down_pin_n[*3] |-> !dout_enable && !din_ctrl_accept &&
    !din_data_accept && !frame_sync_oe && !power.digital_io_on &&
    !power.clock_ctrl_on) else $error("Gate open in hardware power-down.");
  a_no_early_io: assert property (
    (dout_enable || din_ctrl_accept || din_data_accept) |-> chain.ready)
    else $error("Serial gate open before discovery ends.");
  a_ctrl_kept: assert property (
    (chain.ready && !data_frame && power_down_pin_n)[*3] ##0 core_reset_n
    |-> din_ctrl_accept) else $error("Control frame input refused.");
  a_write_taken: assert property (
    power_down_pin_n[*3] ##0 (reg3_write && chain.ready && !reg3_wdata[5])
    |=> reg3_value == $past(reg3_wdata)) else $error("Write not stored.");
  a_soft_reset: assert property (
    power_down_pin_n[*3] ##0 (reg3_write && chain.ready && reg3_wdata[5])
    |=> !core_reset_n ##1 reg3_value == 8'h00)
    else $error("Software reset not applied.");
  a_reset_clears: assert property (
    !core_reset_n |=> chain == '0 && reg3_value == 8'h00)
    else $error("State kept through reset.");
  a_init_length: assert property (
    $rose(core_reset_n) |-> ##131 !chain.ready ##[1:3] chain.ready)
    else $error("Discovery length wrong.");
  a_master_drives: assert property (
    (master_select && power_down_pin_n)[*3] ##0
    (core_reset_n && !chain.ready) |-> frame_sync_oe)
    else $error("Master left frame sync undriven.");
  a_sw_pd_apply: assert property (
    frame_start && reg3_value[7:6] == 2'b11 |=> !power.adc_on &&
    !power.dac_on && !power.analog_out_on)
    else $error("Software power-down not applied.");
  a_sw_pd_leave: assert property (
    (power_down_pin_n && reset_pin_n)[*3] ##0 (frame_start && chain.ready &&
    core_reset_n && reg3_value[7:6] == 2'b00 && !reg3_write)
    |=> power.adc_on && power.dac_on) else $error("Power not restored.");

  // Main scenarios reached.
  c_ready: cover property ($rose(chain.ready));
  c_sw_pd: cover property (frame_start && reg3_value[7:6] == 2'b11);
  c_hw_pd: cover property (!power_down_pin_n[*3]);
endmodule

bind crcp_core crcp_core_monitor u_monitor (.clock, .resetn, .reset_pin_n,
  .power_down_pin_n, .master_select, .frame_start, .data_frame, .reg3_write,
  .reg3_wdata, .frame_sync_oe, .reg3_value, .chain, .dout_enable,
  .din_ctrl_accept, .din_data_accept, .power, .core_reset_n);

// ---- crcp_core_tb.sv ----
// Self-checking bench for the reset, discovery and power-down block.
// Assumes the checker is bound in and the chain model faces the pins.
`timescale 1ns/1ps
module crcp_core_tb;
  localparam int LIMIT = 4000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic reset_pin_n = 1'b0;
  logic power_down_pin_n = 1'b1;
  logic master_select = 1'b1;
  logic port_fs_out = 1'b0;
  logic port_fs_oe = 1'b0;
  logic frame_start = 1'b0;
  logic data_frame = 1'b0;
  logic reg3_write = 1'b0;
  logic [7:0] reg3_wdata = 8'h00;
  logic [4:0] below = 5'h00;
  logic [4:0] above = 5'h00;
  logic fs_out, fs_oe, daisy_out, daisy_oe, fs_wire, daisy_wire;
  logic dout_enable, din_ctrl_accept, din_data_accept, core_reset_n;
  logic [7:0] reg3_value;
  crcp_pkg::crcp_chain_s chain;
  crcp_pkg::crcp_power_s power;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  crcp_core DUT (.clock, .resetn, .reset_pin_n, .power_down_pin_n,
    .master_select, .frame_sync_in(fs_wire), .frame_sync_out(fs_out),
    .frame_sync_oe(fs_oe), .frame_sync_daisy_in(daisy_wire),
    .frame_sync_daisy_out(daisy_out), .frame_sync_daisy_oe(daisy_oe),
    .port_fs_out, .port_fs_oe, .frame_start, .data_frame, .reg3_write,
    .reg3_wdata, .reg3_value, .chain, .dout_enable, .din_ctrl_accept,
    .din_data_accept, .power, .core_reset_n);

  crcp_chain_model far (.clock, .core_reset_n, .fs_drive(fs_out), .fs_oe,
    .daisy_drive(daisy_out), .daisy_oe, .below, .above, .fs_wire,
    .daisy_wire);

  // Master clock at 100 MHz; it never stops, reset included.
  initial begin
    forever #5 clock = ~clock;
  end

  // Comparisons, one task for each width of result.
  task automatic chk_bit(input logic got, input logic exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %b want %b", $time, s, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string s);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h want %h", $time, s, got, exp);
    end
  endtask

  // One control register write, taken at the second edge.
  task automatic wr3(input logic [7:0] v);
    @(posedge clock);
    reg3_write <= 1'b1;
    reg3_wdata <= v;
    @(posedge clock);
    reg3_write <= 1'b0;
    #1;
  endtask

  // One frame start pulse; the frame kind level stays afterwards.
  task automatic frame(input logic df);
    @(posedge clock);
    frame_start <= 1'b1;
    data_frame <= df;
    @(posedge clock);
    frame_start <= 1'b0;
    #1;
  endtask

  // Hardware reset and a full discovery run for one chain shape.
  task automatic run_chain(input logic ms, input logic [4:0] b,
                           input logic [4:0] a);
    int n;
    @(posedge clock);
    master_select <= ms;
    below <= b;
    above <= a;
    reset_pin_n <= 1'b0;
    repeat (crcp_pkg::RESET_PIN_MIN_CYCLES) @(posedge clock);
    reset_pin_n <= 1'b1;
    n = 0;
    while (chain.ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      reg3_write <= (n == 40);
      reg3_wdata <= 8'hC0;
      #1;
      n++;
      if (n == 40) begin
        chk_bit(fs_oe, 1'b1, "phase one fs dir");
        chk_bit(daisy_oe, 1'b0, "phase one daisy dir");
        chk_bit(dout_enable, 1'b0, "dout before ready");
      end
      if (n == 110) begin
        chk_bit(fs_oe, ms, "phase two fs dir");
        if (!ms) chk_bit(daisy_oe, b != 5'h00, "phase two daisy");
      end
    end
    chk_bit(chain.ready, 1'b1, "ready");
    chk_byte({4'h0, chain.address}, {3'h0, b}, "address");
    chk_byte({3'h0, chain.length}, {3'h0, b + a + 5'h01}, "length");
    chk_bit(chain.is_master, ms, "master");
    chk_bit(chain.is_last, b == 5'h00, "last");
    chk_byte(reg3_value, 8'h00, "early write");
    $display("chain test done");
  endtask

  task automatic test_soft_pd;
    wr3(8'hC0);
    chk_byte(reg3_value, 8'hC0, "write taken");
    frame(1'b1);
    chk_bit(power.adc_on, 1'b0, "adc off");
    chk_bit(power.dac_on, 1'b0, "dac off");
    chk_bit(power.analog_out_on, 1'b0, "outputs off");
    chk_bit(dout_enable, 1'b0, "dout data frame");
    chk_bit(din_data_accept, 1'b0, "data dropped");
    @(posedge clock);
    data_frame <= 1'b0;
    #1;
    chk_bit(dout_enable, 1'b1, "dout ctrl frame");
    chk_bit(din_ctrl_accept, 1'b1, "ctrl kept");
    wr3(8'h80);
    frame(1'b1);
    chk_bit(power.adc_on, 1'b0, "adc alone off");
    chk_bit(power.dac_on, 1'b1, "dac alone on");
    chk_bit(din_data_accept, 1'b1, "data taken");
    wr3(8'h00);
    chk_bit(power.adc_on, 1'b0, "waits for frame");
    frame(1'b1);
    chk_bit(power.adc_on, 1'b1, "adc back");
    chk_bit(power.analog_out_on, 1'b1, "outputs back");
    $display("software power-down test done");
  endtask

  task automatic test_hw_pd;
    wr3(8'h40);
    @(posedge clock);
    port_fs_oe <= 1'b1;
    power_down_pin_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk_bit(dout_enable, 1'b0, "dout off");
    chk_bit(din_data_accept, 1'b0, "din off");
    chk_bit(fs_oe, 1'b0, "fs off");
    chk_bit(power.clock_ctrl_on, 1'b0, "clock ctrl off");
    chk_bit(power.digital_io_on, 1'b0, "io off");
    wr3(8'h00);
    chk_byte(reg3_value, 8'h40, "write dropped");
    @(posedge clock);
    power_down_pin_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_bit(power.digital_io_on, 1'b1, "io back");
    chk_bit(fs_oe, 1'b1, "fs back");
    chk_byte(reg3_value, 8'h40, "register kept");
    chk_byte({4'h0, chain.address}, 8'h03, "address kept");
    $display("hardware power-down test done");
  endtask

  task automatic test_sw_reset;
    int n;
    wr3(8'h20);
    chk_bit(core_reset_n, 1'b0, "soft reset");
    @(posedge clock);
    port_fs_oe <= 1'b0;
    #1;
    chk_byte(reg3_value, 8'h00, "register default");
    chk_bit(chain.ready, 1'b0, "chain cleared");
    n = 0;
    while (chain.ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk_byte({4'h0, chain.address}, 8'h03, "rediscovered");
    $display("software reset test done");
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut short well past the longest expected run.
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      close_out;
    end
  end

  // Power-on reset for six cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    run_chain(1'b1, 5'h00, 5'h00);
    run_chain(1'b1, 5'h0F, 5'h00);
    run_chain(1'b0, 5'h00, 5'h01);
    run_chain(1'b0, 5'h02, 5'h01);
    run_chain(1'b1, 5'h03, 5'h00);
    test_soft_pd;
    test_hw_pd;
    test_sw_reset;
    close_out;
  end
endmodule

// ---- crcp_phase_counter.sv ----
// Counts hops within one probing phase and keeps the count at the first
// sighting of the awaited level.
// Assumes clear is held until the phase starts; counts saturate.
`timescale 1ns/1ps
module crcp_phase_counter #(
  parameter int COUNT_W = 5,
  parameter int HOP_CYCLES = 3
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Phase control and the awaited condition.
  input wire logic clear,
  input wire logic active,
  input wire logic seen,
  // Captured hop count and whether it was taken.
  output logic [COUNT_W-1:0] hops,
  output logic found
);

  localparam int SUB_W = $clog2(HOP_CYCLES + 1);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(HOP_CYCLES - 1);

  if (HOP_CYCLES < 1 || COUNT_W < 1) begin : g_bad_params
    $error("crcp_phase_counter needs positive widths and hop length");
  end

  logic [SUB_W-1:0] sub;
  logic [COUNT_W-1:0] run;
  logic [SUB_W-1:0] next_sub;
  logic [COUNT_W-1:0] next_run;
  logic [COUNT_W-1:0] next_hops;
  logic next_found;

  // Cycles in phase divided by the hop length gives the distance.
  always_comb begin
    next_sub = sub;
    next_run = run;
    next_hops = hops;
    next_found = found;
    if (clear) begin
      next_sub = '0;
      next_run = '0;
      next_hops = '0;
      next_found = 1'b0;
    end else if (active) begin
      if (seen && !found) begin
        next_found = 1'b1;
        next_hops = run;
      end
      if (sub == SUB_LAST) begin
        next_sub = '0;
        if (run != {COUNT_W{1'b1}}) begin
          next_run = run + 1'b1;
        end
      end else begin
        next_sub = sub + 1'b1;
      end
    end
  end

  // Counter registers.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sub <= '0;
      run <= '0;
      hops <= '0;
      found <= 1'b0;
    end else begin
      sub <= next_sub;
      run <= next_run;
      hops <= next_hops;
      found <= next_found;
    end
  end

endmodule

// ---- crcp_pkg.sv ----
// Constants, state names and carrier types for the codec reset, cascade
// discovery and power-down block.
// Assumes one master clock at 100 MHz; every count below is in its cycles.
// Operation
// - Low pulse on reset pin starts full reset.
// - Writing one to software reset bit resets.
// - Any reset restores defaults and clears sequential state; the pin sync flops and the reset request clear on power-on reset only.
// - Discovery lasts exactly 132 clocks, any chain.
// - Discovery handles chains of up to sixteen devices.
// - Last device address zero, master holds highest.
// - Phase one drives frame sync; phase two swaps.
// - Master always drives sync; last keeps daisy input.
// - Count clocks until daisy high, then sync low.
// - Chain length and position come from both counts.
// - Power-down bits act at next frame sync.
// - Software power-down tristates output in data frames.
// - Software power-down keeps control writes, drops data.
// - Clearing power-down bits resumes normal operation.
// - Power-down pin low disables clocks, outputs, inputs.
// - Power-down modes preserve all register contents.
package crcp_pkg;

  // Master clock period, in picoseconds.
  localparam int CLOCK_PERIOD_PS = 10000;
  // Whole discovery run and the length of each probing phase, in clocks.
  localparam logic [7:0] INIT_CYCLES = 8'h84;
  localparam logic [7:0] PHASE_CYCLES = 8'h40;
  // Least low time of the hardware reset pin, in clocks.
  localparam int RESET_PIN_MIN_CYCLES = 6;
  // Largest chain and the widths that carry addresses and lengths.
  localparam int MAX_DEVICES = 16;
  localparam int ADDR_W = 4;
  localparam int COUNT_W = 5;
  // Clocks a probe edge needs to pass one device: two sync stages and
  // one output register.
  localparam int SYNC_STAGES = 2;
  localparam int HOP_CYCLES = SYNC_STAGES + 1;

  // Control register 3 layout and reset value.
  localparam int REG3_PD_ADC_BIT = 7;
  localparam int REG3_PD_DAC_BIT = 6;
  localparam int REG3_SW_RESET_BIT = 5;
  localparam logic [7:0] REG3_RESET = 8'h00;

  // Discovery sequencer states.
  typedef enum logic [2:0] {
    CRCP_HOLD,
    CRCP_PROBE_DOWN,
    CRCP_PROBE_UP,
    CRCP_SETTLE,
    CRCP_RUN
  } crcp_state_e;

  // Output level and output enable of one two-way pin.
  typedef struct packed {
    logic drive;
    logic enable;
  } crcp_pin_s;

  // Discovery results.
  typedef struct packed {
    logic ready;
    logic is_master;
    logic is_last;
    logic [COUNT_W-1:0] length;
    logic [ADDR_W-1:0] address;
  } crcp_chain_s;

  // Enables handed to the rest of the codec.
  typedef struct packed {
    logic adc_on;
    logic dac_on;
    logic analog_out_on;
    logic clock_ctrl_on;
    logic digital_io_on;
  } crcp_power_s;

endpackage

// ---- crcp_sync.sv ----
// Two-stage synchroniser for one pin entering the master clock domain.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ps
module crcp_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Pin and its synchronised copy.
  input wire logic pin,
  output logic level
);

  logic first;
  logic next_first;
  logic next_level;

  // Only the second stage is visible outside.
  always_comb begin
    next_first = pin;
    next_level = first;
  end

  // Registers of both stages.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      first <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      first <= next_first;
      level <= next_level;
    end
  end

endmodule
